// ===== verilog/shcm_params.svh
`ifndef SHCM_PARAMS_SVH
`define SHCM_PARAMS_SVH
// ==========================================================
// register offsets
`define SHCM_ADDR_PARAM     8'h17
`define SHCM_ADDR_CMD       8'h18
`define SHCM_ADDR_RESP      8'h20
`define SHCM_ADDR_FLAGS     8'h21
`define SHCM_ADDR_VIS_LOW   8'h22
// ==========================================================
// reset values and the value read at unmapped addresses
`define SHCM_RST_BYTE       8'h00
`define SHCM_READ_UNMAPPED  8'h00
// ==========================================================
// response codes
`define SHCM_ERR_INVALID    8'h80
`define SHCM_ERR_PROX_TWO   8'h89
`define SHCM_ERR_VIS        8'h8C
`define SHCM_ERR_IR         8'h8D
`define SHCM_ERR_AUX        8'h8E
`define SHCM_ERR_BIT        7
`define SHCM_CNT_MSB        3
`define SHCM_CNT_STEP       4'h1
`define SHCM_CNT_PAD        4'h0
// ==========================================================
// command codes that survive a held error (plain defaults)
`define SHCM_CMD_NOP        8'h00
`define SHCM_CMD_RESET      8'h01
// ==========================================================
// interrupt flag positions
`define SHCM_FLAG_CMD       5
`define SHCM_FLAG_PROX3     4
`define SHCM_FLAG_PROX2     3
`define SHCM_FLAG_PROX1     2
`define SHCM_FLAG_ALS_MSB   1
`define SHCM_FLAG_RSVD      2'h0
`define SHCM_RSVD_MSB       7
`define SHCM_RSVD_LSB       6
`endif

// ===== verilog/shcm_pkg.sv
package shcm_pkg;
  typedef enum logic [2:0] {
    SHCM_ERR_NONE    = 3'h0,
    SHCM_ERR_INVCMD  = 3'h1,
    SHCM_ERR_PROXTWO = 3'h2,
    SHCM_ERR_VISOVF  = 3'h3,
    SHCM_ERR_IROVF   = 3'h4,
    SHCM_ERR_AUXOVF  = 3'h5
  } shcm_err_e;

  typedef enum logic [2:0] {
    SHCM_ST_IDLE  = 3'b001,
    SHCM_ST_BUSY  = 3'b010,
    SHCM_ST_ERROR = 3'b100
  } shcm_state_e;

  // sequencer completion report
  typedef struct packed {
    logic      done;
    logic      err;
    shcm_err_e kind;
  } shcm_seq_s;

  // measurement events from the autonomous engine
  typedef struct packed {
    logic       prox3;
    logic       prox2;
    logic       prox1;
    logic [1:0] als;
  } shcm_evt_s;

  // register access strobes from the serial slave
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } shcm_reg_s;
endpackage

// ===== verilog/shcm_mailbox.sv
`timescale 1ns/1ps
`include "shcm_params.svh"
// Notes on behaviour
// - an 8-bit writable parameter mailbox hands a value to the sequencer.
// - each write of the command register submits one command code, except a code other than reset or no-op while an error is held.
// - only a command register write raises the wake pulse.
// - a command error loads an error code into the response register.
// - every error code has its top bit set.
// - a held error code stays until a reset or no-op command.
// - while an error is held other commands are dropped, response unchanged.
// - measurement events keep flowing while an error is held.
// - without error, response bits 3:0 count finished commands, wrapping.
// - completion waits on the sequencer; no fixed latency is assumed.
// - unrecognised command code reports 0x80.
// - second proximity overflow reports 0x89.
// - visible, infrared and auxiliary overflows report 0x8C, 0x8D, 0x8E.
// - flags: command bit 5, proximity bits 4..2, ambient 1:0, 7:6 reserved.
// - interrupt asserts while any flag is set with its enable set.
// - ambient enable lets visible or ultraviolet results assert the interrupt.
module shcm_mailbox (
  input  wire logic               I_CLK,
  input  wire logic               I_RST_N,
  input  wire shcm_pkg::shcm_reg_s I_REG,
  output logic [7:0]              O_REG_RDATA,
  output logic                    O_WAKE,
  output logic                    O_CMD_VALID,
  output logic [7:0]              O_CMD_CODE,
  output logic [7:0]              O_PARAM,
  input  wire shcm_pkg::shcm_seq_s I_SEQ,
  input  wire shcm_pkg::shcm_evt_s I_EVT,
  input  wire logic               I_VIS_READY,
  input  wire logic [15:0]        I_VIS_RESULT,
  input  wire logic [5:0]         I_IRQ_ENABLE,
  output logic [7:0]              O_VIS_HIGH,
  output logic                    O_INT_N
);
  // ==========================================================
  // state
  shcm_pkg::shcm_state_e state;
  shcm_pkg::shcm_state_e next_state;
  logic [7:0]            param;
  logic [7:0]            next_param;
  logic [7:0]            cmd;
  logic [7:0]            next_cmd;
  logic [7:0]            resp;
  logic [7:0]            next_resp;
  logic [7:0]            flags;
  logic [7:0]            next_flags;
  logic [7:0]            vis_low;
  logic [7:0]            next_vis_low;
  logic [7:0]            vis_high;
  logic [7:0]            next_vis_high;
  logic                  wake;
  logic                  next_wake;
  logic                  cmd_valid;
  logic                  next_cmd_valid;
  logic [7:0]            rdata;
  logic [7:0]            next_rdata;
  logic                  int_n;
  logic                  next_int_n;

  logic       wr_cmd;
  logic       clear_ok;
  logic [7:0] err_code;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;

  assign wr_cmd   = I_REG.wr && (I_REG.addr == `SHCM_ADDR_CMD);
  assign clear_ok = (I_REG.wdata == `SHCM_CMD_NOP) || (I_REG.wdata == `SHCM_CMD_RESET);

  // ==========================================================
  // error code map
  always_comb begin
    case (I_SEQ.kind)
      shcm_pkg::SHCM_ERR_INVCMD:  err_code = `SHCM_ERR_INVALID;
      shcm_pkg::SHCM_ERR_PROXTWO: err_code = `SHCM_ERR_PROX_TWO;
      shcm_pkg::SHCM_ERR_VISOVF:  err_code = `SHCM_ERR_VIS;
      shcm_pkg::SHCM_ERR_IROVF:   err_code = `SHCM_ERR_IR;
      shcm_pkg::SHCM_ERR_AUXOVF:  err_code = `SHCM_ERR_AUX;
      default:                    err_code = `SHCM_ERR_INVALID;
    endcase
  end

  // ==========================================================
  // command mailbox and response
  always_comb begin
    next_state     = state;
    next_param     = param;
    next_cmd       = cmd;
    next_resp      = resp;
    next_wake      = 1'b0;
    next_cmd_valid = 1'b0;
    if (I_REG.wr && (I_REG.addr == `SHCM_ADDR_PARAM)) begin
      next_param = I_REG.wdata;
    end
    if (I_REG.wr && (I_REG.addr == `SHCM_ADDR_RESP)) begin
      next_resp = I_REG.wdata;
    end
    // wake depends on the write alone, even if the command is then dropped
    next_wake = wr_cmd;
    case (state)
      shcm_pkg::SHCM_ST_IDLE, shcm_pkg::SHCM_ST_BUSY: begin
        if (wr_cmd) begin
          next_cmd       = I_REG.wdata;
          next_cmd_valid = 1'b1;
          next_state     = shcm_pkg::SHCM_ST_BUSY;
        end
        // completion is whenever the sequencer says so
        if (I_SEQ.err) begin
          next_resp  = err_code;
          next_state = shcm_pkg::SHCM_ST_ERROR;
        end else if (I_SEQ.done && (state == shcm_pkg::SHCM_ST_BUSY)) begin
          next_resp  = {`SHCM_CNT_PAD, resp[`SHCM_CNT_MSB:0] + `SHCM_CNT_STEP};
          next_state = shcm_pkg::SHCM_ST_IDLE;
        end
      end
      shcm_pkg::SHCM_ST_ERROR: begin
        if (wr_cmd && clear_ok) begin
          next_cmd       = I_REG.wdata;
          next_cmd_valid = 1'b1;
          next_resp      = `SHCM_RST_BYTE;
          next_state     = shcm_pkg::SHCM_ST_BUSY;
        end else begin
          next_resp = resp;
        end
      end
      default: begin
        next_state = shcm_pkg::SHCM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state     <= shcm_pkg::SHCM_ST_IDLE;
      param     <= `SHCM_RST_BYTE;
      cmd       <= `SHCM_RST_BYTE;
      resp      <= `SHCM_RST_BYTE;
      wake      <= 1'b0;
      cmd_valid <= 1'b0;
    end else begin
      state     <= next_state;
      param     <= next_param;
      cmd       <= next_cmd;
      resp      <= next_resp;
      wake      <= next_wake;
      cmd_valid <= next_cmd_valid;
    end
  end

  // ==========================================================
  // interrupt flags, visible result, read port
  always_comb begin
    set_bits = `SHCM_RST_BYTE;
    clr_bits = `SHCM_RST_BYTE;
    // measurement events are never gated by a held error
    set_bits[`SHCM_FLAG_CMD]                 = I_SEQ.done;
    set_bits[`SHCM_FLAG_PROX3]               = I_EVT.prox3;
    set_bits[`SHCM_FLAG_PROX2]               = I_EVT.prox2;
    set_bits[`SHCM_FLAG_PROX1]               = I_EVT.prox1;
    set_bits[`SHCM_FLAG_ALS_MSB:0]           = I_EVT.als;
    if (I_REG.wr && (I_REG.addr == `SHCM_ADDR_FLAGS)) begin
      clr_bits = I_REG.wdata;
    end
    // write one to clear; a same-cycle event wins
    next_flags = (flags & ~clr_bits) | set_bits;
    next_flags[`SHCM_RSVD_MSB:`SHCM_RSVD_LSB] = `SHCM_FLAG_RSVD;
    next_int_n = ~|(flags[`SHCM_FLAG_CMD:0] & I_IRQ_ENABLE);
    next_vis_low  = vis_low;
    next_vis_high = vis_high;
    if (I_REG.wr && (I_REG.addr == `SHCM_ADDR_VIS_LOW)) begin
      next_vis_low = I_REG.wdata;
    end
    if (I_VIS_READY) begin
      next_vis_low  = I_VIS_RESULT[7:0];
      next_vis_high = I_VIS_RESULT[15:8];
    end
    next_rdata = rdata;
    if (I_REG.rd) begin
      case (I_REG.addr)
        `SHCM_ADDR_PARAM:   next_rdata = param;
        `SHCM_ADDR_CMD:     next_rdata = cmd;
        `SHCM_ADDR_RESP:    next_rdata = resp;
        `SHCM_ADDR_FLAGS:   next_rdata = flags;
        `SHCM_ADDR_VIS_LOW: next_rdata = vis_low;
        default:            next_rdata = `SHCM_READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      flags    <= `SHCM_RST_BYTE;
      vis_low  <= `SHCM_RST_BYTE;
      vis_high <= `SHCM_RST_BYTE;
      rdata    <= `SHCM_RST_BYTE;
      int_n    <= 1'b1;
    end else begin
      flags    <= next_flags;
      vis_low  <= next_vis_low;
      vis_high <= next_vis_high;
      rdata    <= next_rdata;
      int_n    <= next_int_n;
    end
  end

  assign O_REG_RDATA = rdata;
  assign O_WAKE      = wake;
  assign O_CMD_VALID = cmd_valid;
  assign O_CMD_CODE  = cmd;
  assign O_PARAM     = param;
  assign O_VIS_HIGH  = vis_high;
  assign O_INT_N     = int_n;

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_cmd_write;
    I_REG.wr && (I_REG.addr == `SHCM_ADDR_CMD);
  endsequence
  sequence s_forwarded;
    O_CMD_VALID && (O_CMD_CODE == $past(I_REG.wdata));
  endsequence
  // only a fresh error loads a code; a second one while held is dropped
  sequence s_err_entry;
    I_SEQ.err && (state != shcm_pkg::SHCM_ST_ERROR);
  endsequence

  chk_wake_only_cmd: assert property (O_WAKE == $past(wr_cmd))
    else $error("wake pulse not tied to command write");
  chk_cmd_forward: assert property (
    s_cmd_write and (state != shcm_pkg::SHCM_ST_ERROR) |=> s_forwarded)
    else $error("command write not forwarded");
  chk_param_load: assert property (
    I_REG.wr && (I_REG.addr == `SHCM_ADDR_PARAM) |=> O_PARAM == $past(I_REG.wdata))
    else $error("parameter mailbox not loaded");
  chk_error_entry: assert property (
    s_err_entry |=> (state == shcm_pkg::SHCM_ST_ERROR) && resp[`SHCM_ERR_BIT])
    else $error("error not loaded into response");
  chk_error_msb: assert property (
    state == shcm_pkg::SHCM_ST_ERROR |-> resp[`SHCM_ERR_BIT])
    else $error("held error lacks top bit");
  chk_error_hold: assert property (
    (state == shcm_pkg::SHCM_ST_ERROR) && !(wr_cmd && clear_ok) |=> $stable(resp))
    else $error("held error changed");
  chk_clear_cmd: assert property (
    s_cmd_write and (state == shcm_pkg::SHCM_ST_ERROR) && clear_ok
    |=> (resp == `SHCM_RST_BYTE) && O_CMD_VALID)
    else $error("clearing command did not release error");
  chk_error_ignore: assert property (
    s_cmd_write and (state == shcm_pkg::SHCM_ST_ERROR) && !clear_ok
    |=> !O_CMD_VALID)
    else $error("command forwarded during held error");
  chk_meas_in_error: assert property (
    state == shcm_pkg::SHCM_ST_ERROR |=> (flags[`SHCM_FLAG_PROX3:`SHCM_FLAG_PROX1]
    & $past({I_EVT.prox3, I_EVT.prox2, I_EVT.prox1}))
    == $past({I_EVT.prox3, I_EVT.prox2, I_EVT.prox1}))
    else $error("measurement event lost during held error");
  chk_count_step: assert property (
    (state == shcm_pkg::SHCM_ST_BUSY) && I_SEQ.done && !I_SEQ.err
    && !(I_REG.wr && (I_REG.addr == `SHCM_ADDR_RESP))
    |=> resp[`SHCM_CNT_MSB:0] == $past(resp[`SHCM_CNT_MSB:0]) + `SHCM_CNT_STEP
    && !resp[`SHCM_ERR_BIT])
    else $error("response counter did not step");
  chk_idle_done: assert property (
    (state == shcm_pkg::SHCM_ST_IDLE) && I_SEQ.done && !I_SEQ.err
    && !(I_REG.wr && (I_REG.addr == `SHCM_ADDR_RESP)) |=> $stable(resp))
    else $error("counter stepped with no command outstanding");
  chk_invalid_code: assert property (
    s_err_entry and (I_SEQ.kind == shcm_pkg::SHCM_ERR_INVCMD)
    |=> resp == `SHCM_ERR_INVALID)
    else $error("invalid command code wrong");
  chk_prox_two_code: assert property (
    s_err_entry and (I_SEQ.kind == shcm_pkg::SHCM_ERR_PROXTWO)
    |=> resp == `SHCM_ERR_PROX_TWO)
    else $error("second proximity overflow code wrong");
  chk_vis_ovf_code: assert property (
    s_err_entry and (I_SEQ.kind == shcm_pkg::SHCM_ERR_VISOVF)
    |=> resp == `SHCM_ERR_VIS)
    else $error("visible overflow code wrong");
  chk_ir_ovf_code: assert property (
    s_err_entry and (I_SEQ.kind == shcm_pkg::SHCM_ERR_IROVF)
    |=> resp == `SHCM_ERR_IR)
    else $error("infrared overflow code wrong");
  chk_aux_ovf_code: assert property (
    s_err_entry and (I_SEQ.kind == shcm_pkg::SHCM_ERR_AUXOVF)
    |=> resp == `SHCM_ERR_AUX)
    else $error("auxiliary overflow code wrong");
  chk_rsvd_zero: assert property (
    flags[`SHCM_RSVD_MSB:`SHCM_RSVD_LSB] == `SHCM_FLAG_RSVD)
    else $error("reserved flag bits set");
  chk_cmd_flag: assert property (
    I_SEQ.done |=> flags[`SHCM_FLAG_CMD])
    else $error("command flag not set on completion");
  chk_irq_level: assert property (
    ##1 (O_INT_N == !(|($past(flags[`SHCM_FLAG_CMD:0]) & $past(I_IRQ_ENABLE)))))
    else $error("interrupt output mismatch");
  chk_als_irq: assert property (
    (|I_EVT.als) && I_IRQ_ENABLE[0] && I_IRQ_ENABLE[1] |-> ##2 !O_INT_N)
    else $error("ambient result did not interrupt");
  chk_vis_update: assert property (
    I_VIS_READY |=> vis_low == $past(I_VIS_RESULT[7:0])
    && O_VIS_HIGH == $past(I_VIS_RESULT[15:8]))
    else $error("visible result not captured");
endmodule

// ===== tb/shcm_host_model.sv
`timescale 1ns/1ps
`include "shcm_params.svh"
// ==========================================================
// host model: bus master seen as register strobes
module shcm_host_model (
  input  wire logic          i_clk,
  input  wire logic [7:0]    i_rdata,
  output shcm_pkg::shcm_reg_s o_reg
);
  initial o_reg = '0;
  // released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_reg = '{1'b1, 1'b0, a, d};
    @(posedge i_clk);
    #1;
    o_reg = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_reg = '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk);
    #1;
    o_reg = '{1'b0, 1'b0, ~a, 8'hFF};
    d = i_rdata;
  endtask
  // completion is seen by the counter moving, never by a fixed wait
  task automatic poll(input logic [3:0] prev, output logic [7:0] d);
    for (int n = 0; n < 8; n++) begin
      rd(`SHCM_ADDR_RESP, d);
      if (d[3:0] !== prev) break;
    end
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "shcm_params.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  logic                  clk, rst_n, vis_ready, wake, cmd_valid, int_n;
  shcm_pkg::shcm_reg_s   regs;
  shcm_pkg::shcm_seq_s   seq;
  shcm_pkg::shcm_evt_s   evt;
  logic [7:0]            rdata, cmd_code, param, vis_high, v;
  logic [15:0]           vis_result;
  logic [5:0]            irq_en;
  int                    error_cnt = 0, check_count = 0, cyc = 0;
  shcm_mailbox dut (.I_CLK(clk), .I_RST_N(rst_n), .I_REG(regs), .O_REG_RDATA(rdata),
    .O_WAKE(wake), .O_CMD_VALID(cmd_valid), .O_CMD_CODE(cmd_code), .O_PARAM(param),
    .I_SEQ(seq), .I_EVT(evt), .I_VIS_READY(vis_ready), .I_VIS_RESULT(vis_result),
    .I_IRQ_ENABLE(irq_en), .O_VIS_HIGH(vis_high), .O_INT_N(int_n));
  shcm_host_model host (.i_clk(clk), .i_rdata(rdata), .o_reg(regs));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // closing and hang guard
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  // ==========================================================
  // stimulus helpers
  task automatic seq_pulse(input logic dn, input logic er, input shcm_pkg::shcm_err_e k);
    @(posedge clk);
    #1;
    seq = '{dn, er, k};
    @(posedge clk);
    #1;
    seq = '0;
  endtask
  task automatic evt_pulse(input logic [4:0] e);
    @(posedge clk);
    #1;
    evt = e;
    @(posedge clk);
    #1;
    evt = '0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] a[6] = '{8'h17, 8'h18, 8'h20, 8'h21, 8'h22, 8'h3F};
    foreach (a[i]) begin
      host.rd(a[i], v);
      `CHK("reset read", 8'h00, v)
    end
    `CHK("int idle", 1'b1, int_n)
  endtask
  task automatic t_param();
    host.wr(`SHCM_ADDR_PARAM, 8'hA5);
    `CHK("wake on param", 1'b0, wake)
    `CHK("param out", 8'hA5, param)
    host.wr(`SHCM_ADDR_FLAGS, 8'h00);
    `CHK("wake on flags", 1'b0, wake)
    host.rd(`SHCM_ADDR_PARAM, v);
    `CHK("param read", 8'hA5, v)
  endtask
  task automatic t_count();
    irq_en = 6'h20;
    for (int i = 1; i <= 17; i++) begin
      host.wr(`SHCM_ADDR_CMD, 8'h40 + 8'(i));
      `CHK("wake", 1'b1, wake)
      `CHK("cmd valid", 1'b1, cmd_valid)
      `CHK("cmd code", 8'h40 + 8'(i), cmd_code)
      seq_pulse(1'b1, 1'b0, shcm_pkg::SHCM_ERR_NONE);
      host.poll(4'(i - 1), v);
      `CHK("counter", {4'h0, 4'(i)}, v)
    end
    seq_pulse(1'b1, 1'b0, shcm_pkg::SHCM_ERR_NONE);
    host.rd(`SHCM_ADDR_RESP, v);
    `CHK("idle done", 8'h01, v)
    `CHK("cmd irq", 1'b0, int_n)
    host.rd(`SHCM_ADDR_FLAGS, v);
    `CHK("cmd flag", 8'h20, v)
    host.wr(`SHCM_ADDR_FLAGS, 8'hFF);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq cleared", 1'b1, int_n)
  endtask
  task automatic t_err();
    shcm_pkg::shcm_err_e k[5];
    logic [7:0] c[5] = '{8'h80, 8'h89, 8'h8C, 8'h8D, 8'h8E};
    k = '{shcm_pkg::SHCM_ERR_INVCMD, shcm_pkg::SHCM_ERR_PROXTWO, shcm_pkg::SHCM_ERR_VISOVF,
          shcm_pkg::SHCM_ERR_IROVF, shcm_pkg::SHCM_ERR_AUXOVF};
    irq_en = 6'h04;
    for (int i = 0; i < 5; i++) begin
      host.wr(`SHCM_ADDR_CMD, 8'h42);
      seq_pulse(1'b0, 1'b1, k[i]);
      host.rd(`SHCM_ADDR_RESP, v);
      `CHK("err code", c[i], v)
      `CHK("err msb", 1'b1, v[7])
      host.wr(`SHCM_ADDR_CMD, 8'h42);
      `CHK("dropped cmd", 1'b0, cmd_valid)
      `CHK("wake on dropped", 1'b1, wake)
      seq_pulse(1'b1, 1'b0, shcm_pkg::SHCM_ERR_NONE);
      evt_pulse(5'h04);
      host.rd(`SHCM_ADDR_RESP, v);
      `CHK("err held", c[i], v)
      `CHK("meas irq in err", 1'b0, int_n)
      host.wr(`SHCM_ADDR_FLAGS, 8'hFF);
      host.wr(`SHCM_ADDR_CMD, i[0] ? `SHCM_CMD_RESET : `SHCM_CMD_NOP);
      `CHK("clear cmd", 1'b1, cmd_valid)
      host.rd(`SHCM_ADDR_RESP, v);
      `CHK("err cleared", 8'h00, v)
      seq_pulse(1'b1, 1'b0, shcm_pkg::SHCM_ERR_NONE);
    end
  endtask
  task automatic t_flags();
    irq_en = 6'h00;
    host.wr(`SHCM_ADDR_FLAGS, 8'hFF);
    evt_pulse(5'h01);
    host.rd(`SHCM_ADDR_FLAGS, v);
    `CHK("als flag", 8'h01, v)
    `CHK("als masked", 1'b1, int_n)
    irq_en = 6'h03;
    repeat (2) @(posedge clk);
    #1;
    `CHK("als irq", 1'b0, int_n)
    evt_pulse(5'h1F);
    host.wr(`SHCM_ADDR_FLAGS, 8'hC4);
    host.rd(`SHCM_ADDR_FLAGS, v);
    `CHK("w1c flags", 8'h1B, v)
    host.wr(`SHCM_ADDR_FLAGS, 8'hFF);
  endtask
  task automatic t_vis();
    irq_en = 6'h03;
    @(posedge clk);
    #1;
    vis_ready = 1'b1;
    vis_result = 16'hA55A;
    evt.als = 2'b01;
    @(posedge clk);
    #1;
    vis_ready = 1'b0;
    vis_result = 16'h5AA5;
    evt = '0;
    @(posedge clk);
    #1;
    `CHK("vis irq", 1'b0, int_n)
    host.rd(`SHCM_ADDR_VIS_LOW, v);
    `CHK("vis low", 8'h5A, v)
    `CHK("vis high", 8'hA5, vis_high)
    host.wr(`SHCM_ADDR_VIS_LOW, 8'h3C);
    host.rd(`SHCM_ADDR_VIS_LOW, v);
    `CHK("vis low write", 8'h3C, v)
    @(posedge clk);
    #1;
    vis_ready = 1'b1;
    @(posedge clk);
    #1;
    vis_ready = 1'b0;
    host.rd(`SHCM_ADDR_VIS_LOW, v);
    `CHK("vis next low", 8'hA5, v)
    `CHK("vis next high", 8'h5A, vis_high)
  endtask
  task automatic t_midrst();
    host.wr(`SHCM_ADDR_PARAM, 8'h3C);
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    `CHK("param after reset", 8'h00, param)
    t_reset();
  endtask
  initial begin
    rst_n = 1'b0;
    seq = '0;
    evt = '0;
    vis_ready = 1'b0;
    vis_result = 16'h0000;
    irq_en = 6'h00;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_param();
    t_count();
    t_err();
    t_flags();
    t_vis();
    t_midrst();
    test_done();
  end
endmodule
